// ---- rtl/sbr_pkg.sv ----
// Purpose: constants and types for the scanned bcd readout port
// Assumes: 20 MHz hclk, AHB-Lite register access, 32-bit data
// Notes: all offsets are byte addresses of aligned words
`default_nettype none

package sbr_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned SCAN_HZ = 2250;
  localparam int unsigned SCAN_HALF_DEFAULT = CLK_HZ / (2 * SCAN_HZ);
  localparam int unsigned LATCH_TIME_NS = 1000;
  localparam int unsigned LATCH_CYCLES = (LATCH_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned RESET_TIME_US = 10;
  localparam int unsigned RESET_CYCLES = RESET_TIME_US * (CLK_HZ / 1000000);
  localparam int unsigned SETTLE_CYCLES = 4;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DISPLAY = 8'h04;
  localparam logic [7:0] OFS_CHAIN = 8'h08;
  localparam logic [7:0] OFS_DP_MASK = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_INT_STATUS = 8'h14;
  localparam logic [7:0] OFS_INT_CLEAR = 8'h18;
  localparam logic [7:0] OFS_INT_ENABLE = 8'h1C;

  // ctrl fields
  localparam int unsigned CTRL_TOTALIZE = 0;
  localparam int unsigned CTRL_LATCH = 1;
  localparam int unsigned CTRL_CLEAR = 2;

  // interrupt event bits
  localparam int unsigned EV_OVF = 0;
  localparam int unsigned EV_LATCH = 1;
  localparam int unsigned EV_WRAP = 2;
  localparam int unsigned EV_EXTRST = 3;
  localparam int unsigned NUM_EV = 4;

  // reset values and last scan slot
  localparam logic [7:0] DP_MASK_RESET = 8'h00;
  localparam logic [2:0] SLOT_RESET = 3'h7;
  localparam logic [2:0] SLOT_LAST = 3'h7;

  // latch and reset sequencer
  typedef enum logic [3:0] {
    SBR_IDLE = 4'b0001,
    SBR_LATCH = 4'b0010,
    SBR_CLEAR = 4'b0100,
    SBR_SETTLE = 4'b1000
  } sbr_ctl_t;

endpackage : sbr_pkg

`default_nettype wire

// ---- rtl/sbr_readout.sv ----
// Purpose: rear readout port of a counter, scans eight bcd digits
// Assumes: one 20 MHz clock, AHB-Lite slave, pins synchronised here
// Notes: count chain is an 8-digit bcd totalizer fed from count_in
`default_nettype none

module sbr_readout #(
  parameter int unsigned SCAN_HALF_CYCLES = sbr_pkg::SCAN_HALF_DEFAULT
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // counter pins
  input wire logic count_in,
  input wire logic remote_run_n,
  // reset in/out, open drain
  input wire logic reset_line_in,
  output logic reset_line_out,
  output logic reset_line_oe,
  // scanned readout
  output logic scan_clk,
  output logic [3:0] bcd_out,
  output logic first_slot_strobe,
  output logic dp_strobe,
  output logic overflow,
  output logic data_good,
  output logic ref_clk_out,
  // interrupt
  output logic irq
);
  import sbr_pkg::*;

  // ---------------------------------------------------------------
  // bcd increment
  // ---------------------------------------------------------------
  function automatic logic [32:0] bcd_inc(input logic [31:0] val);
    logic [31:0] res;
    logic carry;
    res = val;
    carry = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (carry) begin
        if (val[i*4 +: 4] == 4'h9) begin
          res[i*4 +: 4] = 4'h0;
        end else begin
          res[i*4 +: 4] = val[i*4 +: 4] + 4'h1;
          carry = 1'b0;
        end
      end
    end
    return {carry, res};
  endfunction : bcd_inc

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic cnt_prev;
  logic rst_prev;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_a <= 3'h7;
      sync_b <= 3'h7;
      cnt_prev <= 1'b1;
      rst_prev <= 1'b1;
    end else begin
      sync_a <= {reset_line_in, remote_run_n, count_in};
      sync_b <= sync_a;
      cnt_prev <= sync_b[0];
      rst_prev <= sync_b[2];
    end
  end

  logic cnt_rise;
  logic run_low;
  logic ext_fall;
  assign cnt_rise = sync_b[0] & ~cnt_prev;
  assign run_low = ~sync_b[1];
  assign ext_fall = ~sync_b[2] & rst_prev;

  // ---------------------------------------------------------------
  // bus, control, counter and interrupt state
  // ---------------------------------------------------------------
  logic dp_valid, next_dp_valid;
  logic dp_write, next_dp_write;
  logic [7:0] dp_addr, next_dp_addr;
  logic rd_wait, next_rd_wait;
  logic [31:0] next_hrdata;
  sbr_ctl_t state, next_state;
  logic [7:0] tmr, next_tmr;
  logic [31:0] chain, next_chain;
  logic [31:0] display, next_display;
  logic ovf, next_ovf;
  logic totalize, next_totalize;
  logic [7:0] dp_mask, next_dp_mask;
  logic [NUM_EV-1:0] int_status, next_int_status;
  logic [NUM_EV-1:0] int_enable, next_int_enable;
  logic wrap_ev;
  logic [2:0] slot;

  logic wr_en;
  logic counting;
  logic [31:0] rd_val;
  logic [NUM_EV-1:0] events;
  logic [NUM_EV-1:0] clr_mask;
  logic [32:0] inc;

  assign wr_en = dp_valid & dp_write;
  assign counting = totalize & run_low & (state != SBR_CLEAR);
  assign hreadyout = ~(dp_valid & ~dp_write & ~rd_wait);
  assign hresp = 1'b0;
  assign reset_line_out = 1'b0;
  assign reset_line_oe = (state == SBR_CLEAR);
  assign data_good = (state == SBR_LATCH);
  assign overflow = ovf;
  assign irq = |(int_status & int_enable);

  always_comb begin
    rd_val = 32'h0;
    unique case (dp_addr)
      OFS_CTRL: rd_val[CTRL_TOTALIZE] = totalize;
      OFS_DISPLAY: rd_val = display;
      OFS_CHAIN: rd_val = chain;
      OFS_DP_MASK: rd_val[7:0] = dp_mask;
      OFS_STATUS: rd_val[5:0] = {counting, ovf, data_good, slot};
      OFS_INT_STATUS: rd_val[NUM_EV-1:0] = int_status;
      OFS_INT_ENABLE: rd_val[NUM_EV-1:0] = int_enable;
      default: rd_val = 32'h0;
    endcase
  end

  always_comb begin
    next_dp_valid = dp_valid;
    next_dp_write = dp_write;
    next_dp_addr = dp_addr;
    next_rd_wait = 1'b0;
    next_hrdata = hrdata;
    next_state = state;
    next_tmr = tmr;
    next_chain = chain;
    next_display = display;
    next_ovf = ovf;
    next_totalize = totalize;
    next_dp_mask = dp_mask;
    next_int_enable = int_enable;
    events = '0;
    clr_mask = '0;
    inc = bcd_inc(chain);
    // bus phases
    if (hready) begin
      next_dp_valid = hsel & htrans[1];
      next_dp_write = hwrite;
      next_dp_addr = haddr[7:0];
    end
    if (dp_valid & ~dp_write & ~rd_wait) begin
      next_rd_wait = 1'b1;
      next_hrdata = rd_val;
    end
    if (wr_en) begin
      unique case (dp_addr)
        OFS_CTRL: next_totalize = hwdata[CTRL_TOTALIZE];
        OFS_DP_MASK: next_dp_mask = hwdata[7:0];
        OFS_INT_CLEAR: clr_mask = hwdata[NUM_EV-1:0];
        OFS_INT_ENABLE: next_int_enable = hwdata[NUM_EV-1:0];
        default: ;
      endcase
    end
    // count chain
    if (counting && cnt_rise) begin
      next_chain = inc[31:0];
      if (inc[32]) begin
        next_ovf = 1'b1;
        events[EV_OVF] = 1'b1;
      end
    end
    // latch and reset sequencer
    unique case (state)
      SBR_IDLE: begin
        if (wr_en && dp_addr == OFS_CTRL && hwdata[CTRL_CLEAR]) begin
          next_chain = 32'h0;
          next_ovf = 1'b0;
          next_tmr = 8'(RESET_CYCLES - 1);
          next_state = SBR_CLEAR;
        end else if (ext_fall) begin
          next_chain = 32'h0;
          next_ovf = 1'b0;
          events[EV_EXTRST] = 1'b1;
        end else if (wr_en && dp_addr == OFS_CTRL && hwdata[CTRL_LATCH]) begin
          next_tmr = 8'(LATCH_CYCLES - 1);
          next_state = SBR_LATCH;
        end
      end
      SBR_LATCH: begin
        next_tmr = tmr - 8'h1;
        if (tmr == 8'h0) begin
          next_display = chain;
          events[EV_LATCH] = 1'b1;
          next_state = SBR_IDLE;
        end
      end
      SBR_CLEAR: begin
        next_chain = 32'h0;
        next_tmr = tmr - 8'h1;
        if (tmr == 8'h0) begin
          next_tmr = 8'(SETTLE_CYCLES - 1);
          next_state = SBR_SETTLE;
        end
      end
      SBR_SETTLE: begin
        next_tmr = tmr - 8'h1;
        if (tmr == 8'h0) begin
          next_state = SBR_IDLE;
        end
      end
      default: next_state = SBR_IDLE;
    endcase
    events[EV_WRAP] = wrap_ev;
    next_int_status = (int_status & ~clr_mask) | events;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
      rd_wait <= 1'b0;
      hrdata <= 32'h0;
      state <= SBR_IDLE;
      tmr <= 8'h00;
      chain <= 32'h0;
      display <= 32'h0;
      ovf <= 1'b0;
      totalize <= 1'b0;
      dp_mask <= DP_MASK_RESET;
      int_status <= '0;
      int_enable <= '0;
    end else begin
      dp_valid <= next_dp_valid;
      dp_write <= next_dp_write;
      dp_addr <= next_dp_addr;
      rd_wait <= next_rd_wait;
      hrdata <= next_hrdata;
      state <= next_state;
      tmr <= next_tmr;
      chain <= next_chain;
      display <= next_display;
      ovf <= next_ovf;
      totalize <= next_totalize;
      dp_mask <= next_dp_mask;
      int_status <= next_int_status;
      int_enable <= next_int_enable;
    end
  end

  // ---------------------------------------------------------------
  // digit scanner and reference clock
  // ---------------------------------------------------------------
  logic [15:0] scan_cnt, next_scan_cnt;
  logic next_scan_clk;
  logic [2:0] next_slot;
  logic [3:0] next_bcd_out;
  logic next_first_slot_strobe;
  logic next_dp_strobe;
  logic next_ref_clk_out;
  logic [2:0] digit_pos;

  always_comb begin
    next_scan_cnt = scan_cnt + 16'h1;
    next_scan_clk = scan_clk;
    next_slot = slot;
    next_bcd_out = bcd_out;
    next_first_slot_strobe = first_slot_strobe;
    next_dp_strobe = dp_strobe;
    next_ref_clk_out = ~ref_clk_out;
    wrap_ev = 1'b0;
    digit_pos = SLOT_LAST - (slot + 3'h1);
    if (scan_cnt == 16'(SCAN_HALF_CYCLES - 1)) begin
      next_scan_cnt = 16'h0;
      next_scan_clk = ~scan_clk;
      if (scan_clk) begin
        next_slot = slot + 3'h1;
        next_bcd_out = display[{digit_pos, 2'b00} +: 4];
        next_first_slot_strobe = (slot == SLOT_LAST);
        next_dp_strobe = dp_mask[slot + 3'h1];
        wrap_ev = (slot == SLOT_LAST);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scan_cnt <= 16'h0;
      scan_clk <= 1'b0;
      slot <= SLOT_RESET;
      bcd_out <= 4'h0;
      first_slot_strobe <= 1'b0;
      dp_strobe <= 1'b0;
      ref_clk_out <= 1'b0;
    end else begin
      scan_cnt <= next_scan_cnt;
      scan_clk <= next_scan_clk;
      slot <= next_slot;
      bcd_out <= next_bcd_out;
      first_slot_strobe <= next_first_slot_strobe;
      dp_strobe <= next_dp_strobe;
      ref_clk_out <= next_ref_clk_out;
    end
  end

endmodule : sbr_readout

`default_nettype wire

// ---- verification/sbr_capture.sv ----
// Purpose: external digit capture logic
// Assumes: samples the readout with hclk
// Notes: drops a frame touched by data good
`default_nettype none

module sbr_capture (
  // inputs
  input wire logic hclk,
  input wire logic scan_clk,
  input wire logic [3:0] bcd_out,
  input wire logic first_slot_strobe,
  input wire logic dp_strobe,
  input wire logic data_good,
  // captured frame
  output logic [31:0] frame,
  output logic [7:0] dp_frame,
  output int frames
);
  logic prev = 1'b0;
  logic bad = 1'b0;
  int s = 8;
  logic [31:0] acc;
  logic [7:0] dacc;
  initial frames = 0;
  always @(posedge hclk) begin
    prev <= scan_clk;
    if (scan_clk && !prev) begin // capture on rising scan edge
      s = first_slot_strobe ? 0 : (s < 8 ? s + 1 : 8);
      bad = (first_slot_strobe ? 1'b0 : bad) | data_good; // skip while copying
      if (s < 8) begin
        acc[31 - 4 * s -: 4] = bcd_out;
        dacc[s] = dp_strobe;
      end
      if (s == 7 && !bad) begin
        frame <= acc;
        dp_frame <= dacc;
        frames <= frames + 1;
      end
    end
  end
endmodule : sbr_capture

`default_nettype wire

// ---- verification/sbr_readout_properties.sv ----
// Purpose: port checks for sbr_readout
// Assumes: bound into every sbr_readout
// Notes: scan timing follows SCAN_HALF_CYCLES
`default_nettype none

module sbr_props #(
  parameter int unsigned SCAN_HALF_CYCLES = 8
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus answer
  input wire logic hreadyout,
  input wire logic hresp,
  // readout
  input wire logic scan_clk,
  input wire logic [3:0] bcd_out,
  input wire logic first_slot_strobe,
  input wire logic dp_strobe,
  input wire logic data_good,
  input wire logic ref_clk_out,
  input wire logic reset_line_out,
  input wire logic reset_line_oe
);
  import sbr_pkg::*;
  logic last;
  logic seen;
  logic [15:0] hold;
  logic [2:0] slot;
  logic [7:0] dg;
  logic [15:0] fs_len;
  // ----
  // helper counters
  // ----
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last <= 1'b0;
      seen <= 1'b0;
      hold <= 16'h0;
      slot <= 3'h7;
      dg <= 8'h0;
      fs_len <= 16'h0;
    end else begin
      last <= scan_clk;
      seen <= seen | (scan_clk != last);
      hold <= (scan_clk != last) ? 16'h0 : hold + 16'h1;
      slot <= (last && !scan_clk) ? slot + 3'h1 : slot;
      dg <= data_good ? dg + 8'h1 : 8'h0;
      fs_len <= first_slot_strobe ? fs_len + 16'h1 : 16'h0;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  scan_half_a: assert property (scan_clk != last && seen |-> hold == SCAN_HALF_CYCLES - 1)
    else $error("scan half period wrong");
  digit_edge_a: assert property ($changed(bcd_out) || $changed(first_slot_strobe)
    || $changed(dp_strobe) |-> $fell(scan_clk)) else $error("readout changed off falling edge");
  slot_order_a: assert property ($fell(scan_clk) |-> first_slot_strobe == (slot == 3'h7))
    else $error("first slot out of order");
  strobe_hold_a: assert property ($rose(first_slot_strobe) |-> first_slot_strobe [*8])
    else $error("first slot strobe too short");
  strobe_len_a: assert property ($fell(first_slot_strobe)
    |-> fs_len == 16'(2 * SCAN_HALF_CYCLES)) else $error("first slot strobe length wrong");
  ref_clk_a: assert property ($past(hresetn) |-> ref_clk_out != $past(ref_clk_out))
    else $error("reference clock stalled");
  latch_len_a: assert property ($fell(data_good) |-> dg == LATCH_CYCLES)
    else $error("data good width wrong");
  reset_drive_a: assert property (reset_line_oe |-> !reset_line_out)
    else $error("reset line not driven low");
  ready_pulse_a: assert property (!hreadyout |=> hreadyout && !hresp)
    else $error("wait state too long");
  cover property ($rose(data_good));
  cover property ($rose(reset_line_oe));
  cover property ($rose(dp_strobe));
endmodule : sbr_props

bind sbr_readout sbr_props #(.SCAN_HALF_CYCLES(SCAN_HALF_CYCLES)) u_props (.hclk(hclk),
  .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .scan_clk(scan_clk),
  .bcd_out(bcd_out), .first_slot_strobe(first_slot_strobe), .dp_strobe(dp_strobe),
  .data_good(data_good), .ref_clk_out(ref_clk_out), .reset_line_out(reset_line_out),
  .reset_line_oe(reset_line_oe));

`default_nettype wire

// ---- verification/tb_top.sv ----
// Purpose: self-checking bench for sbr_readout
// Assumes: 20 MHz hclk, short scan period
// Notes: count_in acts as the 400 ns link clock
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import sbr_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic count_in = 1'b0;
  logic remote_run_n = 1'b1;
  logic ext_pull = 1'b0;
  logic hreadyout, hresp, oe, rl_out, scan_clk, fss, dps, ovf, dg, refc, irq;
  logic [31:0] hrdata, rd, frame;
  logic [3:0] bcd;
  logic [7:0] dpf, mask;
  int frames, n, t, f0;
  int err_count = 0;
  int total_checks = 0;
  wire logic rline = !(oe && !rl_out) && !ext_pull;
  always #25 hclk = ~hclk;
  sbr_readout #(.SCAN_HALF_CYCLES(8)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .count_in(count_in), .remote_run_n(remote_run_n), .reset_line_in(rline),
    .reset_line_out(rl_out), .reset_line_oe(oe), .scan_clk(scan_clk), .bcd_out(bcd),
    .first_slot_strobe(fss), .dp_strobe(dps), .overflow(ovf), .data_good(dg),
    .ref_clk_out(refc), .irq(irq));
  sbr_capture u_cap (.hclk(hclk), .scan_clk(scan_clk), .bcd_out(bcd), .first_slot_strobe(fss),
    .dp_strobe(dps), .data_good(dg), .frame(frame), .dp_frame(dpf), .frames(frames));
  // ----
  // helpers
  // ----
  function automatic logic [31:0] bcd_of(input int v);
    logic [31:0] r;
    for (int i = 0; i < 8; i++) begin
      r[4 * i +: 4] = 4'(v % 10);
      v = v / 10;
    end
    return r;
  endfunction : bcd_of
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    #1;
  endtask : ahb
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic pulses(input int k);
    #($urandom % 20);
    repeat (k) begin
      #200 count_in = 1'b1;
      #200 count_in = 1'b0;
    end
    repeat (10) @(posedge hclk);
  endtask : pulses
  task automatic tally_and_finish;
    if (err_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #2000000;
    err_count++;
    tally_and_finish;
  end
  // ----
  // scenarios
  // ----
  initial begin
    void'($urandom(32'h1f9e));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, OFS_DP_MASK, 32'h0, rd);
    chk(rd, {24'h0, DP_MASK_RESET});
    ahb(1'b0, 8'h40, 32'h0, rd);
    chk(rd, 32'h0);
    n = 1 + $urandom % 40;
    ahb(1'b1, OFS_CTRL, 32'h1, rd);
    remote_run_n <= 1'b0;
    pulses(n);
    remote_run_n <= 1'b1;
    pulses(1 + $urandom % 5);
    ahb(1'b0, OFS_CHAIN, 32'h0, rd);
    chk(rd, bcd_of(n));
    ahb(1'b1, OFS_INT_ENABLE, 32'h2, rd);
    ahb(1'b1, OFS_CTRL, 32'h3, rd);
    for (t = 0; t < 100 && irq !== 1'b1; t++) @(posedge hclk) #1;
    chk({31'h0, irq}, 32'h1);
    ahb(1'b0, OFS_DISPLAY, 32'h0, rd);
    chk(rd, bcd_of(n));
    ahb(1'b1, OFS_INT_CLEAR, 32'h2, rd);
    @(posedge hclk) #1;
    chk({31'h0, irq}, 32'h0);
    mask = 8'($urandom);
    ahb(1'b1, OFS_DP_MASK, {24'h0, mask}, rd);
    f0 = frames;
    for (t = 0; t < 1000 && frames < f0 + 2; t++) @(posedge hclk) #1;
    chk({31'h0, frames >= f0 + 2}, 32'h1);
    chk(frame, bcd_of(n));
    chk({24'h0, dpf}, {24'h0, mask});
    ahb(1'b1, OFS_CTRL, 32'h5, rd);
    for (t = 0; t < 20 && oe !== 1'b1; t++) @(posedge hclk) #1;
    for (t = 0; t < 1000 && oe === 1'b1; t++) @(posedge hclk) #1;
    chk(t, RESET_CYCLES);
    repeat (10) @(posedge hclk) #1;
    ahb(1'b0, OFS_CHAIN, 32'h0, rd);
    chk(rd, 32'h0);
    remote_run_n <= 1'b0;
    pulses(3);
    ext_pull <= 1'b1;
    repeat (4) @(posedge hclk) #1;
    ext_pull <= 1'b0;
    repeat (10) @(posedge hclk) #1;
    ahb(1'b0, OFS_CHAIN, 32'h0, rd);
    chk(rd, 32'h0);
    ahb(1'b0, OFS_INT_STATUS, 32'h0, rd);
    chk(rd & 32'h8, 32'h8);
    chk({31'h0, ovf}, 32'h0);
    ahb(1'b0, OFS_STATUS, 32'h0, rd);
    chk(rd & 32'h38, 32'h20);
    chk({31'h0, irq}, 32'h0);
    ahb(1'b1, OFS_INT_ENABLE, 32'hA, rd);
    chk({31'h0, irq}, 32'h1);
    ahb(1'b1, OFS_INT_CLEAR, 32'h8, rd);
    @(posedge hclk) #1;
    chk({31'h0, irq}, 32'h0);
    tally_and_finish;
  end
endmodule : tb_top

`default_nettype wire
